// File: shared/adcprc_pkg.sv
// constants, types and behaviour list for the adc power and reference control block
//
// Behaviour
// R1 - power-on defaults: channel zero, internal clock, supply reference
// R2 - result memory undefined until a conversion completes
// R3 - idle powers analog down, reference excluded; code also powers the reference down unless internal always-on
// R4 - external clock: idle only after stop, nack, restart
// R5 - internal clock: power down once scan stored
// R6 - internal results kept until stop or restart
// R7 - valid address byte wakes the converter
// R8 - reference needs 10 ms before use
// R9 - decode reference select bits into source and pin
// R10 - always-on reference stays until select rewritten
// R11 - pin reference output high impedance in shutdown
// R12 - pin-role set: differential uses ground instead
// R13 - single-ended scan limit excludes shared pin
// R14 - unipolar straight binary, bipolar two's complement
// R15 - conversion clock select defaults to internal
// R16 - internal clock: hold serial clock low converting
// R17 - digital side and memory stay powered
package adcprc_pkg;
  localparam int RES_BITS = 12;
  localparam int CH_W = 4;
  localparam int MCLK_HZ = 40_000_000;
  localparam int REF_WAKE_MS = 10;
  localparam int REF_WAKE_CYC = MCLK_HZ / 1000 * REF_WAKE_MS;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [CH_W-1:0] CH_ZERO = 4'h0;
  localparam logic [CH_W-1:0] CH_TWO = 4'h2;
  localparam logic [CH_W-1:0] CH_TEN = 4'hA;
  localparam logic [CH_W-1:0] CH_SHARED_SMALL = 4'h3;
  localparam logic [CH_W-1:0] CH_SHARED_LARGE = 4'hB;
  localparam logic [RES_BITS-1:0] MSB_FLIP = 12'h800;

  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_HOLD} adcprc_state_t;

  typedef struct packed {
    logic ref_internal_select;
    logic ref_pin_role_select;
    logic ref_always_on_select;
  } adcprc_sel_t;

  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_prev;
    logic sda_prev;
  } adcprc_sync_t;
endpackage

// File: verilog/adcprc_top.sv
// power-state, reference decode and result coding for the adc control block
`timescale 1ns/1ps
module adcprc_top
  import adcprc_pkg::*;
#(
  parameter int WAKE_CYC = REF_WAKE_CYC,
  parameter logic [CH_W-1:0] TOP_CH = CH_SHARED_LARGE
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // two-wire bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  // events from the serial front end, same clock
  input wire logic ADDR_MATCH,
  input wire logic NACK_SEEN,
  input wire logic SETUP_WR,
  input wire logic [2:0] SETUP_SEL,
  input wire logic SETUP_CLK_EXT,
  input wire logic CONFIG_WR,
  input wire logic CONFIG_DIFF,
  input wire logic CONFIG_BIPOLAR,
  input wire logic [CH_W-1:0] CONFIG_CH,
  input wire logic SCAN_DONE,
  input wire logic [RES_BITS-1:0] RAW_RESULT,
  // status and controls
  output logic ANALOG_ON,
  output logic REF_ON,
  output logic REF_READY,
  output logic PIN_REF_DRIVE,
  output logic PIN_REF_INPUT,
  output logic USE_INT_REF,
  output logic CLK_EXT,
  output logic DIFF_GND_SUB,
  output logic [CH_W-1:0] SCAN_LIMIT,
  output logic MEM_VALID,
  output logic DIGITAL_ON,
  output logic [RES_BITS-1:0] CODE_OUT,
  output logic BIPOLAR
);

  typedef struct packed {
    adcprc_state_t st;
    adcprc_sync_t sy;
    adcprc_sel_t sel;
    logic clk_ext;
    logic diff;
    logic bip;
    logic [CH_W-1:0] ch;
    logic mem_valid;
    logic ref_on;
    logic [31:0] wake_cnt;
    logic ref_ready;
    logic [RES_BITS-1:0] code;
    logic [CH_W-1:0] limit;
  } adcprc_reg_t;

  adcprc_reg_t r_q, r_d;
  logic start_c, stop_c, ref_want;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    r_d = r_q;
    r_d.sy.scl_s1 = SCL_IN;
    r_d.sy.scl_s2 = r_q.sy.scl_s1;
    r_d.sy.sda_s1 = SDA_IN;
    r_d.sy.sda_s2 = r_q.sy.sda_s1;
    r_d.sy.scl_prev = r_q.sy.scl_s2;
    r_d.sy.sda_prev = r_q.sy.sda_s2;
    // start covers repeated start too
    start_c = r_q.sy.scl_s2 && r_q.sy.scl_prev && r_q.sy.sda_prev && !r_q.sy.sda_s2;
    stop_c = r_q.sy.scl_s2 && r_q.sy.scl_prev && !r_q.sy.sda_prev && r_q.sy.sda_s2;
    if (SETUP_WR) begin
      if (SETUP_SEL != r_q.sel) begin
        r_d.ref_on = 1'b0; // [R10]
      end
      r_d.sel = SETUP_SEL; // [R9]
      r_d.clk_ext = SETUP_CLK_EXT; // [R15]
    end
    if (CONFIG_WR) begin
      r_d.diff = CONFIG_DIFF;
      r_d.bip = CONFIG_BIPOLAR;
      r_d.ch = CONFIG_CH;
    end
    case (r_q.st)
      ST_IDLE: begin
        if (ADDR_MATCH) begin
          r_d.st = ST_CONVERT; // [R7]
        end
      end
      ST_CONVERT: begin
        if (r_q.clk_ext) begin
          if (stop_c || start_c || NACK_SEEN) begin
            r_d.st = ST_IDLE; // [R4] [R3]
          end
        end else if (SCAN_DONE) begin
          r_d.st = ST_HOLD; // [R5]
          r_d.mem_valid = 1'b1; // [R2]
        end
      end
      ST_HOLD: begin
        if (stop_c || start_c) begin
          r_d.st = ST_IDLE; // [R6]
        end else if (ADDR_MATCH) begin
          r_d.st = ST_CONVERT;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase
    if (r_q.clk_ext && SCAN_DONE) begin
      r_d.mem_valid = 1'b1; // [R2]
    end
    // reference held on by the always-on setting, or while converting with it
    ref_want = r_d.sel.ref_internal_select &&
      (r_d.sel.ref_always_on_select || r_d.st == ST_CONVERT);
    if (r_d.sel.ref_internal_select && r_d.sel.ref_always_on_select) begin
      r_d.ref_on = 1'b1; // [R10]
    end else begin
      r_d.ref_on = ref_want; // [R3]
    end
    if (!r_d.ref_on) begin
      r_d.wake_cnt = '0;
      r_d.ref_ready = 1'b0;
    end else if (r_q.wake_cnt >= WAKE_CYC - 1) begin
      r_d.ref_ready = 1'b1; // [R8]
    end else begin
      r_d.wake_cnt = r_q.wake_cnt + 32'h0000_0001;
    end
    // bipolar flips msb of offset-binary raw code
    // mode taken from r_d so code and BIPOLAR flag always leave together
    r_d.code = r_d.bip ? (RAW_RESULT ^ MSB_FLIP) : RAW_RESULT; // [R14]
    r_d.limit = r_d.ch > TOP_CH ? TOP_CH : r_d.ch;
    if (r_d.sel.ref_pin_role_select && !r_d.diff && r_d.limit == TOP_CH) begin
      r_d.limit = (TOP_CH == CH_SHARED_SMALL) ? CH_TWO : CH_TEN; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      r_q <= '0; // [R1]
      r_q.st <= ST_IDLE;
      r_q.sel <= SEL_RESET; // [R1]
      r_q.clk_ext <= 1'b0; // [R15]
      r_q.ch <= CH_ZERO; // [R1]
      r_q.limit <= CH_ZERO;
      r_q.mem_valid <= 1'b0; // [R2]
      r_q.sy <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs are all separate flops, loaded from the next-state struct r_d except the constant SCL_OUT and DIGITAL_ON
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      SCL_OUT <= 1'b0;
      SCL_OE <= 1'b0;
      ANALOG_ON <= 1'b0;
      REF_ON <= 1'b0;
      REF_READY <= 1'b0;
      PIN_REF_DRIVE <= 1'b0;
      PIN_REF_INPUT <= 1'b0;
      USE_INT_REF <= 1'b0;
      CLK_EXT <= 1'b0;
      DIFF_GND_SUB <= 1'b0;
      SCAN_LIMIT <= CH_ZERO;
      MEM_VALID <= 1'b0;
      // digital side never drops, not even in reset
      DIGITAL_ON <= 1'b1; // [R17]
      CODE_OUT <= '0;
      BIPOLAR <= 1'b0;
    end else begin
      SCL_OUT <= 1'b0;
      SCL_OE <= r_d.st == ST_CONVERT && !r_d.clk_ext; // [R16]
      ANALOG_ON <= r_d.st == ST_CONVERT; // [R3]
      REF_ON <= r_d.ref_on;
      REF_READY <= r_d.ref_ready;
      // pin drive only while reference runs and not shut down
      PIN_REF_DRIVE <= r_d.sel.ref_internal_select && r_d.sel.ref_pin_role_select &&
        r_d.ref_on && (r_d.st == ST_CONVERT || r_d.sel.ref_always_on_select); // [R11]
      PIN_REF_INPUT <= !r_d.sel.ref_internal_select && r_d.sel.ref_pin_role_select; // [R9]
      USE_INT_REF <= r_d.sel.ref_internal_select; // [R9]
      CLK_EXT <= r_d.clk_ext;
      DIFF_GND_SUB <= r_d.sel.ref_pin_role_select && r_d.diff; // [R12]
      SCAN_LIMIT <= r_d.limit;
      MEM_VALID <= r_d.mem_valid;
      DIGITAL_ON <= 1'b1; // [R17]
      CODE_OUT <= r_d.code;
      BIPOLAR <= r_d.bip;
    end
  end

  ////////////////////////////////////////////////////////////////////
  property p_wake;
    @(posedge MCLK) disable iff (SRST)
      (r_q.st == ST_IDLE && ADDR_MATCH) |=> ANALOG_ON;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on address"); // [R7]

  property p_int_done;
    @(posedge MCLK) disable iff (SRST)
      (r_q.st == ST_CONVERT && !r_q.clk_ext && SCAN_DONE) |=> (!ANALOG_ON && !SCL_OE);
  endproperty
  a_int_done: assert property (p_int_done) else $error("no shutdown after scan"); // [R5]

  property p_ext_stop;
    @(posedge MCLK) disable iff (SRST)
      (r_q.st == ST_CONVERT && r_q.clk_ext && NACK_SEEN) |=> !ANALOG_ON;
  endproperty
  a_ext_stop: assert property (p_ext_stop) else $error("ext mode not idle on nack"); // [R4]

  property p_ref_ready;
    @(posedge MCLK) disable iff (SRST)
      $rose(REF_READY) |-> $past(REF_ON);
  endproperty
  a_ref_ready: assert property (p_ref_ready) else $error("ready without reference"); // [R8]

  property p_pin_hiz;
    @(posedge MCLK) disable iff (SRST)
      PIN_REF_DRIVE |-> (REF_ON && USE_INT_REF);
  endproperty
  a_pin_hiz: assert property (p_pin_hiz) else $error("pin driven while off"); // [R11]

  property p_stretch;
    @(posedge MCLK) disable iff (SRST)
      SCL_OE |-> (ANALOG_ON && !CLK_EXT && !SCL_OUT);
  endproperty
  a_stretch: assert property (p_stretch) else $error("bad clock stretch"); // [R16]

  property p_gnd;
    @(posedge MCLK) disable iff (SRST)
      DIFF_GND_SUB |-> $past(r_d.sel.ref_pin_role_select);
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground substitution wrong"); // [R12]

  property p_limit;
    @(posedge MCLK) disable iff (SRST)
      (r_q.sel.ref_pin_role_select && !r_q.diff) |-> (SCAN_LIMIT != TOP_CH);
  endproperty
  a_limit: assert property (p_limit) else $error("limit includes shared pin"); // [R13]

  property p_digital;
    @(posedge MCLK) disable iff (SRST)
      !ANALOG_ON |-> DIGITAL_ON;
  endproperty
  a_digital: assert property (p_digital) else $error("digital side off"); // [R17]

  property p_defaults;
    @(posedge MCLK) disable iff (SRST)
      $past(SRST) |-> (!CLK_EXT && !USE_INT_REF && !BIPOLAR && SCAN_LIMIT == CH_ZERO);
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad defaults"); // [R1]

  property p_hold_keep;
    @(posedge MCLK) disable iff (SRST)
      (r_q.st == ST_HOLD && !stop_c && !start_c && !ADDR_MATCH) |=>
        (r_q.st == ST_HOLD && MEM_VALID);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("results dropped early"); // [R6]

  property p_hold_exit;
    @(posedge MCLK) disable iff (SRST)
      (r_q.st == ST_HOLD && (stop_c || start_c)) |=> (r_q.st == ST_IDLE);
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("hold not left on stop"); // [R6]

  property p_ext_wait;
    @(posedge MCLK) disable iff (SRST)
      (r_q.st == ST_CONVERT && r_q.clk_ext && !stop_c && !start_c && !NACK_SEEN) |=>
        ANALOG_ON;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("ext mode idle too soon"); // [R4]

  property p_mem_valid;
    @(posedge MCLK) disable iff (SRST)
      $rose(MEM_VALID) |-> $past(SCAN_DONE);
  endproperty
  a_mem_valid: assert property (p_mem_valid) else $error("memory valid unasked"); // [R2]

  property p_ref_idle;
    @(posedge MCLK) disable iff (SRST)
      (!ANALOG_ON && !(r_q.sel.ref_internal_select && r_q.sel.ref_always_on_select)) |->
        !REF_ON;
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("reference left on idle"); // [R3]

  property p_ref_keep;
    @(posedge MCLK) disable iff (SRST)
      (r_q.sel.ref_internal_select && r_q.sel.ref_always_on_select && !SETUP_WR) |=>
        REF_ON;
  endproperty
  a_ref_keep: assert property (p_ref_keep) else $error("always-on reference lost"); // [R10]

  property p_pin_input;
    @(posedge MCLK) disable iff (SRST)
      PIN_REF_INPUT |-> (!USE_INT_REF && !PIN_REF_DRIVE);
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin role clash"); // [R9]

  property p_code;
    @(posedge MCLK) disable iff (SRST)
      !$past(SRST) |->
        (CODE_OUT == (BIPOLAR ? ($past(RAW_RESULT) ^ MSB_FLIP) : $past(RAW_RESULT)));
  endproperty
  a_code: assert property (p_code) else $error("output coding wrong"); // [R14]

  property p_stretch_int;
    @(posedge MCLK) disable iff (SRST)
      (r_q.st == ST_CONVERT && !r_q.clk_ext) |-> SCL_OE;
  endproperty
  a_stretch_int: assert property (p_stretch_int) else $error("clock not held"); // [R16]

  property p_limit_cap;
    @(posedge MCLK) disable iff (SRST)
      SCAN_LIMIT <= TOP_CH;
  endproperty
  a_limit_cap: assert property (p_limit_cap) else $error("limit past top channel"); // [R13]
endmodule

// File: bench/adcprc_bus_master.sv
// two-wire bus master model for the adc control block
`timescale 1ns/1ps
module adcprc_bus_master (
  // bus lines, pulled up when released
  output logic scl,
  output logic sda
);
  // clock stands high outside frames, as the pull-up leaves it
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start or repeated start: data falls while clock is high, clock then low
  task automatic bus_start();
    sda = 1'b1;
    #100 scl = 1'b1;
    #100 sda = 1'b0;
    #100 scl = 1'b0;
    #100;
  endtask
  // stop: data rises while clock is high, both lines then stay released
  task automatic bus_stop();
    sda = 1'b0;
    #100 scl = 1'b1;
    #100 sda = 1'b1;
    #100;
  endtask
endmodule

// File: bench/adcprc_tb.sv
// self-checking bench for the adc power and reference control block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb;
  import adcprc_pkg::*;
  localparam int WAKE = 20;
  logic mclk, srst = 1'b1, scl, sda, diff = 1'b0, bip = 1'b0, ext = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [2:0] sel = 3'h0;
  logic [CH_W-1:0] ch = 4'h0;
  logic [RES_BITS-1:0] raw = 12'h000;
  logic scl_out, scl_oe, an_on, ref_on, ref_rdy, pin_drv, pin_in, int_ref, clk_x;
  logic gnd_sub, mem_v, dig_on, bip_o;
  logic [CH_W-1:0] lim;
  logic [RES_BITS-1:0] code;
  int fails = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  adcprc_top #(.WAKE_CYC(WAKE), .TOP_CH(CH_SHARED_LARGE)) i_dut (.MCLK(mclk), .SRST(srst),
    .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .ADDR_MATCH(ev[0]),
    .NACK_SEEN(ev[1]), .SETUP_WR(ev[2]), .SETUP_SEL(sel), .SETUP_CLK_EXT(ext),
    .CONFIG_WR(ev[3]), .CONFIG_DIFF(diff), .CONFIG_BIPOLAR(bip), .CONFIG_CH(ch),
    .SCAN_DONE(ev[4]), .RAW_RESULT(raw), .ANALOG_ON(an_on), .REF_ON(ref_on),
    .REF_READY(ref_rdy), .PIN_REF_DRIVE(pin_drv), .PIN_REF_INPUT(pin_in),
    .USE_INT_REF(int_ref), .CLK_EXT(clk_x), .DIFF_GND_SUB(gnd_sub), .SCAN_LIMIT(lim),
    .MEM_VALID(mem_v), .DIGITAL_ON(dig_on), .CODE_OUT(code), .BIPOLAR(bip_o));
  adcprc_bus_master i_master (.scl(scl), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // event bits: address, nack, setup, config, scan done
  task automatic pulse(input logic [4:0] m);
    ev = m;
    step(1);
    ev = 5'h00;
    step(2);
  endtask
  task automatic setup(input logic [2:0] s, input logic x);
    sel = s;
    ext = x;
    pulse(5'h04);
  endtask
  task automatic set_config(input logic d, input logic b, input logic [CH_W-1:0] c);
    diff = d;
    bip = b;
    ch = c;
    pulse(5'h08);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(clk_x, 1'b0)
    `CHK({int_ref, pin_in, pin_drv, bip_o}, 4'h0)
    `CHK(lim, CH_ZERO)
    `CHK(mem_v, 1'b0)
    `CHK({an_on, ref_on}, 2'b00)
    `CHK(dig_on, 1'b1)
  endtask
  task automatic t_internal();
    pulse(5'h01);
    `CHK(an_on, 1'b1)
    `CHK({scl_oe, scl_out}, 2'b10)
    step(5);
    `CHK(an_on, 1'b1)
    pulse(5'h10);
    `CHK({an_on, scl_oe}, 2'b00)
    step(10);
    `CHK({mem_v, dig_on}, 2'b11)
  endtask
  task automatic t_external();
    setup(3'h0, 1'b1);
    `CHK(clk_x, 1'b1)
    pulse(5'h01);
    pulse(5'h10);
    `CHK({an_on, scl_oe, mem_v}, 3'b101)
    pulse(5'h02);
    `CHK(an_on, 1'b0)
    i_master.bus_start();
    pulse(5'h01);
    `CHK(an_on, 1'b1)
    i_master.bus_stop();
    step(2);
    `CHK(an_on, 1'b0)
    i_master.bus_start();
    pulse(5'h01);
    i_master.bus_start();
    step(2);
    `CHK(an_on, 1'b0)
    i_master.bus_stop();
    setup(3'h0, 1'b0);
  endtask
  task automatic t_ref();
    for (int i = 0; i < 8; i++) begin
      setup(i[2:0], 1'b0);
      `CHK(int_ref, i[2])
      `CHK(pin_in, i[2:1] == 2'b01)
      `CHK(ref_on, i[2] & i[0])
    end
    setup(3'h6, 1'b0);
    `CHK(pin_drv, 1'b0)
    pulse(5'h01);
    `CHK(pin_drv, 1'b1)
    pulse(5'h10);
    `CHK(pin_drv, 1'b0)
    setup(3'h5, 1'b0);
    `CHK(ref_rdy, 1'b0)
    step(WAKE + 2);
    `CHK(ref_rdy, 1'b1)
    setup(3'h5, 1'b0);
    `CHK(ref_on, 1'b1)
    setup(3'h4, 1'b0);
    `CHK(ref_on, 1'b0)
  endtask
  task automatic t_pin();
    setup(3'h2, 1'b0);
    set_config(1'b1, 1'b0, CH_TEN);
    `CHK(gnd_sub, 1'b1)
    set_config(1'b0, 1'b0, 4'hF);
    `CHK(lim, CH_TEN)
    setup(3'h0, 1'b0);
    set_config(1'b0, 1'b0, 4'hF);
    `CHK(lim, 4'hB)
    set_config(1'b1, 1'b0, CH_TEN);
    `CHK(gnd_sub, 1'b0)
  endtask
  task automatic t_code();
    raw = 12'h0123;
    set_config(1'b0, 1'b1, 4'h0);
    `CHK({bip_o, code}, 13'h1923)
    raw = 12'h0FFF;
    step(2);
    `CHK(code, 12'h07FF)
    set_config(1'b0, 1'b0, 4'h0);
    `CHK({bip_o, code}, 13'h0FFF)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // whole run is a few hundred cycles; this leaves ample room
  initial begin
    #50_000;
    fails++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    step(20);
    srst = 1'b0;
    step(2);
    t_reset();
    t_internal();
    t_external();
    t_ref();
    t_pin();
    t_code();
    final_report();
  end
endmodule
